/* File: core/sgsel_defines.svh */
// Purpose: shared constants of the settings bank selector
// Assumes: included by every design file of the selector
// Notes: offsets are byte addresses on the register bus
//
// How it works
// - coil contact lost: bank two ends up active
// - internal logic signals accepted as bank requests
// - no automatic return to bank one
// - held bank two takes over after drop
// - ON and OFF event per condition change
// - event mode passes ON, OFF or both
// - every event carries its time stamp
// - remote and local request events
// - unconfigured bank request raises failure event
// - priority reject and force failure events
// - bank one highest; static request blocks lower
// - remote ignored while higher bank held
// - force overrides local until disabled
`ifndef SGSEL_DEFINES_SVH
`define SGSEL_DEFINES_SVH

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define SGSEL_NBANK 8
`define SGSEL_NCOND 16
`define SGSEL_CODEW 5
`define SGSEL_STAMPW 32
`define SGSEL_AW 8

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define SGSEL_OFF_CTRL 8'h00
`define SGSEL_OFF_FORCE 8'h04
`define SGSEL_OFF_REMOTE 8'h08
`define SGSEL_OFF_LOCAL 8'h0C
`define SGSEL_OFF_STATUS 8'h10
`define SGSEL_OFF_IRQ_STAT 8'h14
`define SGSEL_OFF_IRQ_MASK 8'h18
`define SGSEL_OFF_STAMP 8'h1C
// ctrl: used banks minus one [2:0], force enable [3], event mode [5:4]
`define SGSEL_CTRL_RESET 32'h0000_0030
`define SGSEL_CTRL_FEN 3
`define SGSEL_CTRL_MODE_HI 5
`define SGSEL_CTRL_MODE_LO 4
// bank request field: 0 none, 1..8 bank number
`define SGSEL_REQ_HI 3
`define SGSEL_REQ_NONE 4'h0
// status bits beyond the active bank in [2:0]
`define SGSEL_ST_NCFG 4
`define SGSEL_ST_PRIO 5
`define SGSEL_ST_FFAIL 6
`define SGSEL_ST_REQ 7
`define SGSEL_ST_FEN 8

// ---------------------------------------------------------------
// event conditions, code = 2 * condition + (1 for OFF)
// ---------------------------------------------------------------
`define SGSEL_C_BANKS28 0
`define SGSEL_C_REQ 1
`define SGSEL_C_REMOTE 2
`define SGSEL_C_LOCAL 3
`define SGSEL_C_FORCE 4
`define SGSEL_C_FNCFG 5
`define SGSEL_C_FFORCE 6
`define SGSEL_C_FPRIO 7
`define SGSEL_C_ACT0 8

// ---------------------------------------------------------------
// interrupt bits
// ---------------------------------------------------------------
`define SGSEL_IRQ_W 4
`define SGSEL_IRQ_CHG 0
`define SGSEL_IRQ_NCFG 1
`define SGSEL_IRQ_PRIO 2
`define SGSEL_IRQ_FFAIL 3

`endif

/* File: core/sgsel_pkg.sv */
// Purpose: types of the settings bank selector
// Assumes: sgsel_defines.svh gives the widths
// Notes: event records travel as one packed struct
`include "sgsel_defines.svh"
package sgsel_pkg;
  // bit 0 passes ON events, bit 1 passes OFF events
  typedef enum logic [1:0] {EVM_NONE, EVM_ON, EVM_OFF, EVM_BOTH} sgsel_evmode_e;
  // bank index 0..7, zero is bank one
  typedef logic [2:0] sgsel_bank_t;
  // one time-stamped event record
  typedef struct packed {
    logic [`SGSEL_CODEW-1:0] code;
    logic [`SGSEL_STAMPW-1:0] stamp;
  } sgsel_event_s;
endpackage : sgsel_pkg

/* File: core/sgsel_sync.sv */
// Purpose: two-stage synchroniser for the bank request pins
// Assumes: pins are asynchronous to sys_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
`include "sgsel_defines.svh"
module sgsel_sync import sgsel_pkg::*; #(
  parameter int W = `SGSEL_NBANK
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_r; // first stage, metastable risk

  // ---------------------------------------------------------------
  // double flop over the whole vector, one process drives both stages
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      pin_sync <= '0;
    end else begin
      meta_r <= pin_in;
      pin_sync <= meta_r;
    end
  end
endmodule : sgsel_sync

/* File: core/sgsel_evq.sv */
// Purpose: edge events with time stamps toward the event buffer
// Assumes: conditions are levels on sys_clk
// Notes: a re-raised pending event is merged, newest stamp kept
`timescale 1ns/1ns
`include "sgsel_defines.svh"
module sgsel_evq import sgsel_pkg::*; #(
  parameter int N = `SGSEL_NCOND
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [N-1:0] cond,
  input wire sgsel_evmode_e mode,
  input wire logic [`SGSEL_STAMPW-1:0] stamp,
  output logic evt_valid,
  input wire logic evt_ready,
  output sgsel_event_s evt_r
);
  logic [N-1:0] prev_r; // condition one cycle ago
  logic [2*N-1:0] pend_r; // codes waiting to go out
  logic [`SGSEL_STAMPW-1:0] stamp_mem [2*N]; // stamp at occurrence
  logic [2*N-1:0] raise; // new edges after the mode filter
  logic [2*N-1:0] pick; // one-hot code leaving now
  logic [`SGSEL_CODEW-1:0] pick_code;
  logic load;
  // low in the first cycle out of reset, so reset levels raise no false edge
  logic armed_r;

  // out stage free or being drained
  assign load = (!evt_valid || evt_ready) && (|pend_r);

  // ---------------------------------------------------------------
  // edge detect and filter
  // ---------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_edge
    assign raise[2*i] = cond[i] && !prev_r[i] && mode[0] && armed_r;
    assign raise[2*i+1] = !cond[i] && prev_r[i] && mode[1] && armed_r;
  end

  // lowest pending code goes first
  always_comb begin
    pick = '0;
    pick_code = '0;
    for (int j = 2*N-1; j >= 0; j--) begin
      if (pend_r[j]) begin
        pick = '0;
        pick[j] = 1'b1;
        pick_code = j[`SGSEL_CODEW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // pending bits: a fresh edge wins over the pop
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= '0;
      pend_r <= '0;
      armed_r <= 1'b0;
    end else begin
      prev_r <= cond;
      armed_r <= 1'b1;
      pend_r <= (pend_r & ~(load ? pick : '0)) | raise;
    end
  end

  // stamp taken at the edge itself
  always_ff @(posedge sys_clk) begin
    for (int k = 0; k < 2*N; k++) begin
      if (raise[k]) begin
        stamp_mem[k] <= stamp;
      end
    end
  end

  // registered output towards the buffer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_valid <= 1'b0;
      evt_r <= '0;
    end else if (load) begin
      evt_valid <= 1'b1;
      evt_r <= '{code: pick_code, stamp: stamp_mem[pick_code]};
    end else if (evt_ready) begin
      evt_valid <= 1'b0;
    end
  end

  evt_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    evt_valid && !evt_ready |=> evt_valid && $stable(evt_r))
    else $error("event record changed before it was taken");
endmodule : sgsel_evq

/* File: core/sgsel_top.sv */
// Purpose: priority selector of eight settings banks with events
// Assumes: APB slave, zero wait states, 20 MHz sys_clk
// Notes: remote, local and force commands are register writes
`timescale 1ns/1ns
`include "sgsel_defines.svh"
module sgsel_top import sgsel_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SGSEL_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bank requests: pins (async) and internal logic (sys_clk)
  input wire logic [`SGSEL_NBANK-1:0] bank_req_pin,
  input wire logic [`SGSEL_NBANK-1:0] bank_req_app,
  // selection towards protection functions
  output logic [`SGSEL_NBANK-1:0] bank_active_r,
  // event buffer
  output logic evt_valid,
  input wire logic evt_ready,
  output sgsel_event_s evt_r,
  output logic irq
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // {found, index} of the highest priority request
  function automatic logic [3:0] first_req(input logic [`SGSEL_NBANK-1:0] v);
    logic [3:0] r;
    r = '0;
    for (int i = `SGSEL_NBANK-1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, i[2:0]};
      end
    end
    return r;
  endfunction : first_req

  // bank lies inside the configured range
  function automatic logic in_cfg(input sgsel_bank_t b, input sgsel_bank_t used);
    return b <= used;
  endfunction : in_cfg

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] ctrl_r; // used banks, force enable, event mode
  logic [`SGSEL_REQ_HI:0] frc_bank_r; // last forced bank number
  logic [`SGSEL_REQ_HI:0] rem_bank_r; // latched remote command
  logic [`SGSEL_REQ_HI:0] loc_bank_r; // latched local command
  logic frc_pend_r, rem_pend_r, loc_pend_r; // one-cycle command pulses
  sgsel_bank_t active_r; // bank in use, zero is bank one
  logic fail_ncfg_r, fail_prio_r, fail_force_r; // failure conditions
  logic [`SGSEL_IRQ_W-1:0] irq_stat_r, irq_mask_r;
  logic [`SGSEL_STAMPW-1:0] stamp_r; // free-running time base
  logic [`SGSEL_NBANK-1:0] pin_sync; // synchronised pins

  // pins cross into sys_clk before anything reads them
  sgsel_sync #(.W(`SGSEL_NBANK)) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin_in(bank_req_pin),
    .pin_sync(pin_sync)
  );

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  wire sgsel_bank_t used = ctrl_r[2:0];
  wire fen = ctrl_r[`SGSEL_CTRL_FEN];
  // contacts and any internal signal combination are equal sources
  wire [`SGSEL_NBANK-1:0] req_lvl = pin_sync | bank_req_app;
  wire [3:0] lvl = first_req(req_lvl);
  wire lvl_any = lvl[3];
  wire sgsel_bank_t lvl_idx = lvl[2:0];
  wire sgsel_bank_t rem_idx = 3'(rem_bank_r - 4'h1);
  wire sgsel_bank_t loc_idx = 3'(loc_bank_r - 4'h1);
  wire sgsel_bank_t frc_idx = 3'(frc_bank_r - 4'h1);
  // a held higher bank shuts out the command
  wire rem_blk = lvl_any && (lvl_idx < rem_idx);
  wire loc_blk = lvl_any && (lvl_idx < loc_idx);
  // forcing: only force commands move the bank
  wire frc_ok = fen && frc_pend_r && in_cfg(frc_idx, used);
  wire frc_bad = frc_pend_r && !(fen && in_cfg(frc_idx, used));
  wire cmd_forced = fen && (loc_pend_r || rem_pend_r);
  wire rem_ok = !fen && rem_pend_r && !rem_blk && in_cfg(rem_idx, used);
  wire loc_ok = !fen && loc_pend_r && !loc_blk && in_cfg(loc_idx, used);
  wire lvl_ok = !fen && lvl_any && in_cfg(lvl_idx, used);
  wire prio_bad = !fen && ((rem_pend_r && rem_blk) || (loc_pend_r && loc_blk));
  wire ncfg_bad = !fen && ((rem_pend_r && !rem_blk && !in_cfg(rem_idx, used)) ||
                           (loc_pend_r && !loc_blk && !in_cfg(loc_idx, used)) ||
                           (lvl_any && !in_cfg(lvl_idx, used)));
  wire acc = frc_ok || rem_ok || loc_ok || lvl_ok;
  // priority chain of accepted sources
  wire sgsel_bank_t bank_nxt = frc_ok ? frc_idx :
                               rem_ok ? rem_idx :
                               loc_ok ? loc_idx :
                               lvl_ok ? lvl_idx : active_r;
  wire chg = bank_nxt != active_r;

  // ---------------------------------------------------------------
  // bank register: holds until another source is accepted
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_r <= '0;
    end else begin
      active_r <= bank_nxt;
    end
  end

  // one-hot view for the protection functions
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_active_r <= 8'h01;
    end else begin
      bank_active_r <= 8'(1) << bank_nxt;
    end
  end

  // failure flags: set wins, cleared by a good acceptance
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fail_ncfg_r <= 1'b0;
      fail_prio_r <= 1'b0;
      fail_force_r <= 1'b0;
    end else begin
      fail_ncfg_r <= ncfg_bad || (fail_ncfg_r && !acc);
      fail_prio_r <= prio_bad || (fail_prio_r && !acc);
      fail_force_r <= frc_bad || cmd_forced || (fail_force_r && !acc);
    end
  end

  // time base for stamps
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stamp_r <= '0;
    end else begin
      stamp_r <= stamp_r + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire hit_ctrl = paddr == `SGSEL_OFF_CTRL;
  wire hit_frc = paddr == `SGSEL_OFF_FORCE;
  wire hit_rem = paddr == `SGSEL_OFF_REMOTE;
  wire hit_loc = paddr == `SGSEL_OFF_LOCAL;
  wire hit_st = paddr == `SGSEL_OFF_STATUS;
  wire hit_is = paddr == `SGSEL_OFF_IRQ_STAT;
  wire hit_im = paddr == `SGSEL_OFF_IRQ_MASK;
  wire hit_ts = paddr == `SGSEL_OFF_STAMP;
  wire mapped = hit_ctrl || hit_frc || hit_rem || hit_loc || hit_st || hit_is ||
                hit_im || hit_ts;
  wire [3:0] wbank = pwdata[`SGSEL_REQ_HI:0];
  wire wcmd = wr && (wbank != `SGSEL_REQ_NONE); // zero means no request
  wire [31:0] status = {23'h0, fen, (|req_lvl), fail_force_r, fail_prio_r,
                        fail_ncfg_r, 1'b0, active_r};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_frc ? {28'h0, frc_bank_r} :
                       hit_st ? status :
                       hit_is ? {28'h0, irq_stat_r} :
                       hit_im ? {28'h0, irq_mask_r} :
                       hit_ts ? stamp_r : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read data captured in the setup cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // writable registers and command pulses
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `SGSEL_CTRL_RESET;
      frc_bank_r <= `SGSEL_REQ_NONE;
      rem_bank_r <= `SGSEL_REQ_NONE;
      loc_bank_r <= `SGSEL_REQ_NONE;
      frc_pend_r <= 1'b0;
      rem_pend_r <= 1'b0;
      loc_pend_r <= 1'b0;
      irq_mask_r <= '0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_r <= {26'h0, pwdata[`SGSEL_CTRL_MODE_HI:0]};
      end
      if (wr && hit_im) begin
        irq_mask_r <= pwdata[`SGSEL_IRQ_W-1:0];
      end
      if (wcmd && hit_frc) begin
        frc_bank_r <= wbank;
      end
      if (wcmd && hit_rem) begin
        rem_bank_r <= wbank;
      end
      if (wcmd && hit_loc) begin
        loc_bank_r <= wbank;
      end
      frc_pend_r <= wcmd && hit_frc; // pulse operation
      rem_pend_r <= wcmd && hit_rem;
      loc_pend_r <= wcmd && hit_loc;
    end
  end

  // ---------------------------------------------------------------
  // interrupts: sticky, write one to clear, new event wins
  // ---------------------------------------------------------------
  wire [`SGSEL_IRQ_W-1:0] irq_set = {frc_bad || cmd_forced, prio_bad, ncfg_bad, chg};
  wire [`SGSEL_IRQ_W-1:0] irq_clr = (wr && hit_is) ? pwdata[`SGSEL_IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ---------------------------------------------------------------
  // event conditions
  // ---------------------------------------------------------------
  wire [`SGSEL_NCOND-1:0] cond = {bank_active_r,
                                  fail_prio_r, fail_force_r, fail_ncfg_r,
                                  fen,
                                  loc_pend_r, rem_pend_r,
                                  (|req_lvl), (active_r != 3'h0)};

  sgsel_evq #(.N(`SGSEL_NCOND)) u_evq (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cond(cond),
    .mode(sgsel_evmode_e'(ctrl_r[`SGSEL_CTRL_MODE_HI:`SGSEL_CTRL_MODE_LO])),
    .stamp(stamp_r),
    .evt_valid(evt_valid),
    .evt_ready(evt_ready),
    .evt_r(evt_r)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  bank_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !acc |=> $stable(active_r))
    else $error("bank moved with no accepted source");
  lvl_pick_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lvl_ok && !rem_ok && !loc_ok |=> active_r == $past(lvl_idx))
    else $error("highest held request not selected");
  bank_two_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !fen && req_lvl[1:0] == 2'b10 && !rem_ok && !loc_ok && used != 3'h0
    |=> active_r == 3'h1 && bank_active_r == 8'h02)
    else $error("held bank two did not take over");
  rem_block_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !fen && rem_pend_r && rem_blk |=> fail_prio_r &&
    (active_r != $past(rem_idx) || $stable(active_r)))
    else $error("blocked remote change was applied");
  force_over_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fen && loc_pend_r && !frc_pend_r |=> fail_force_r && $stable(active_r))
    else $error("local change passed while forced");
  force_apply_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    frc_ok |=> active_r == $past(frc_idx))
    else $error("forced bank not applied");
  ncfg_fail_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !fen && lvl_any && !in_cfg(lvl_idx, used) |=> fail_ncfg_r)
    else $error("unconfigured request not flagged");
  chg_irq_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    chg |=> irq_stat_r[`SGSEL_IRQ_CHG] && bank_active_r[active_r] && $onehot(bank_active_r))
    else $error("bank change not reported");

  // blocked and unconfigured commands
  loc_block_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !fen && loc_pend_r && loc_blk |=> fail_prio_r)
    else $error("blocked local change not flagged");
  ncfg_cmd_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !fen && rem_pend_r && !rem_blk && !in_cfg(rem_idx, used) |=> fail_ncfg_r)
    else $error("unconfigured remote change not flagged");

  // failure interrupts and force failures
  prio_irq_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    prio_bad |=> irq_stat_r[`SGSEL_IRQ_PRIO])
    else $error("priority reject not latched");
  frc_fail_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    frc_bad |=> fail_force_r)
    else $error("failed force request not flagged");
  ffail_irq_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    frc_bad || cmd_forced |=> irq_stat_r[`SGSEL_IRQ_FFAIL])
    else $error("force failure not latched");

  // force keeps the bank until a force command moves it
  fen_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fen && !frc_pend_r |=> $stable(active_r))
    else $error("bank moved while forced");
endmodule : sgsel_top

/* File: bench/sgsel_src.sv */
// Purpose: request sources beside the selector
// Assumes: contacts have pull-downs, so a broken wire reads 0
// Notes: two-wire coil status, held bank two, cold load output
`timescale 1ns/1ns
`include "sgsel_defines.svh"
module sgsel_src import sgsel_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic coil_no, // coil closed contact
  input wire logic coil_nc, // coil open contact
  input wire logic hold_two, // permanent bank two request
  input wire logic cold_load, // cold load pick-up output
  output logic [`SGSEL_NBANK-1:0] bank_req_pin,
  output logic [`SGSEL_NBANK-1:0] bank_req_app
);
  logic coil_r; // supervised coil state
  // ----------------------------------------
  // supervision
  // ----------------------------------------
  // agreeing contacts keep the last state: one lost wire is harmless
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      coil_r <= 1'b1;
    else if (coil_no != coil_nc)
      coil_r <= coil_no;
  end
  // coil connected requests bank one only while it is seen
  assign bank_req_pin = {7'h0, coil_r};
  // internal logic drives bank two and bank three requests
  assign bank_req_app = {5'h0, cold_load, hold_two, 1'b0};
endmodule : sgsel_src

/* File: bench/settings_bank_selector_events_test.sv */
// Purpose: self-checking bench of the settings bank selector
// Assumes: commands land one edge after the write edge
// Notes: random bank commands mixed with fixed corner cases
`timescale 1ns/1ns
`include "sgsel_defines.svh"
module settings_bank_selector_events_test import sgsel_pkg::*; ;
  localparam logic [7:0] a_ctl = `SGSEL_OFF_CTRL;
  localparam logic [7:0] a_rmt = `SGSEL_OFF_REMOTE;
  localparam logic [7:0] a_loc = `SGSEL_OFF_LOCAL;
  localparam logic [7:0] a_st = `SGSEL_OFF_STATUS;
  logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, seen = 0, s1, stamp_rem = 0;
  logic pready, pslverr, evt_valid, evt_ready = 0, irq, last_err;
  logic coil_no = 1, coil_nc = 0, hold_two = 1, cold_load = 0; // far side levels
  logic [7:0] bank_req_pin, bank_req_app, bank_active_r;
  sgsel_event_s evt_r;
  int bad_count = 0, n_tests = 0, cyc = 0, b;

  sgsel_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bank_req_pin(bank_req_pin), .bank_req_app(bank_req_app),
    .bank_active_r(bank_active_r), .evt_valid(evt_valid), .evt_ready(evt_ready),
    .evt_r(evt_r), .irq(irq));
  sgsel_src src_u (.sys_clk(sys_clk), .reset_n(reset_n), .coil_no(coil_no),
    .coil_nc(coil_nc), .hold_two(hold_two), .cold_load(cold_load),
    .bank_req_pin(bank_req_pin), .bank_req_app(bank_req_app));

  // ----------------------------------------
  // clock
  // ----------------------------------------
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task check(input logic [31:0] sv, input logic [31:0] ev);
    n_tests++;
    if (sv !== ev) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, sv, ev);
    end
  endtask : check
  // one apb transfer; read data lands in q
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task waitc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : waitc
  // command write, then room for pulse and update
  task cmd(input logic [7:0] a, input int bk);
    apb(1'b1, a, 32'(bk));
    waitc(3);
  endtask : cmd
  function logic [7:0] onehot(input int bk);
    return 8'h01 << (bk - 1);
  endfunction : onehot
  // one-hot output and status index agree with bank bk
  task exp_bank(input int bk);
    check(32'(bank_active_r), 32'(onehot(bk)));
    apb(1'b0, a_st, 32'h0000_0000);
    check(32'(q[2:0]), 32'(bk - 1));
  endtask : exp_bank
  task st_bit(input int i);
    apb(1'b0, a_st, 32'h0000_0000);
    check(32'(q[i]), 32'h0000_0001);
  endtask : st_bit

  // ----------------------------------------
  // event sink and timeout
  // ----------------------------------------
  // ready toggles at random so records must wait
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      conclude();
    end
    if (evt_valid === 1'b1 && evt_ready === 1'b1) begin
      seen[evt_r.code] = 1'b1;
      if (evt_r.code == 5'h04)
        stamp_rem = evt_r.stamp;
    end
    evt_ready <= 1'($urandom % 2);
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h6a85));
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    check(32'(bank_active_r), 32'h0000_0001);
    apb(1'b0, a_ctl, 32'h0000_0000);
    check(q, `SGSEL_CTRL_RESET);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check(32'(last_err), 32'h0000_0001);
    apb(1'b1, `SGSEL_OFF_IRQ_MASK, 32'h0000_0004);
    apb(1'b1, a_ctl, 32'h0000_0037);
    waitc(5);
    exp_bank(1);
    coil_no <= 1'b0;
    waitc(6);
    exp_bank(1);
    coil_nc <= 1'b1;
    waitc(6);
    exp_bank(2);
    cmd(a_rmt, 3);
    exp_bank(2);
    cmd(a_loc, 4);
    exp_bank(2);
    // the held request is re-accepted every cycle, so the flag only lives in the sticky bit
    apb(1'b0, `SGSEL_OFF_IRQ_STAT, 32'h0000_0000);
    check(32'(q[`SGSEL_IRQ_PRIO]), 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    apb(1'b1, `SGSEL_OFF_IRQ_STAT, 32'h0000_000f);
    check(32'(irq), 32'h0000_0000);
    hold_two <= 1'b0;
    waitc(6);
    exp_bank(2);
    cold_load <= 1'b1;
    waitc(4);
    exp_bank(3);
    cold_load <= 1'b0;
    repeat (12) begin
      b = 1 + $urandom % 8;
      cmd((b % 2) ? a_rmt : a_loc, b);
      exp_bank(b);
    end
    apb(1'b1, a_ctl, 32'h0000_0032);
    cmd(a_rmt, 1);
    cmd(a_rmt, 6);
    exp_bank(1);
    st_bit(`SGSEL_ST_NCFG);
    apb(1'b1, a_ctl, 32'h0000_003a);
    cmd(`SGSEL_OFF_FORCE, 2);
    exp_bank(2);
    apb(1'b0, `SGSEL_OFF_FORCE, 32'h0000_0000);
    check(q, 32'h0000_0002);
    cmd(a_loc, 3);
    exp_bank(2);
    st_bit(`SGSEL_ST_FFAIL);
    apb(1'b1, a_ctl, 32'h0000_0032);
    waitc(20);
    // codes 0,4..10,12,14,17,18 must all have appeared
    check(seen & 32'h0006_57f1, 32'h0006_57f1);
    // force command with forcing off must fail and leave the bank
    apb(1'b1, `SGSEL_OFF_IRQ_STAT, 32'h0000_000f);
    cmd(`SGSEL_OFF_FORCE, 3);
    exp_bank(2);
    apb(1'b0, `SGSEL_OFF_IRQ_STAT, 32'h0000_0000);
    check(32'(q[`SGSEL_IRQ_FFAIL]), 32'h0000_0001);
    seen = 0;
    apb(1'b1, a_ctl, 32'h0000_0012);
    cmd(a_rmt, 3);
    waitc(20);
    s1 = stamp_rem;
    cmd(a_rmt, 1);
    waitc(20);
    check(seen & 32'haaaa_aaaa, 32'h0000_0000);
    check(32'(stamp_rem > s1), 32'h0000_0001);
    seen = 0;
    apb(1'b1, a_ctl, 32'h0000_0022);
    cmd(a_rmt, 2);
    waitc(20);
    check(seen & 32'h5555_5555, 32'h0000_0000);
    check(32'(seen[5]), 32'h0000_0001);
    // event mode none: nothing reaches the buffer
    seen = 0;
    apb(1'b1, a_ctl, 32'h0000_0002);
    cmd(a_rmt, 1);
    waitc(20);
    check(seen, 32'h0000_0000);
    conclude();
  end
endmodule : settings_bank_selector_events_test
